//--- design/scs_pkg.sv
`default_nettype none
package scs_pkg;
  // register byte offsets on the apb bus
  localparam logic [7:0] SCS_OFF_SRC = 8'h00;
  localparam logic [7:0] SCS_OFF_INT = 8'h04;
  localparam logic [7:0] SCS_OFF_EXT = 8'h08;
  localparam logic [7:0] SCS_OFF_MUL = 8'h0C;

  // field positions
  localparam int SCS_SRC_LSB = 0;
  localparam int SCS_ACT_LSB = 4;
  localparam int SCS_INT_DIV_LSB = 0;
  localparam int SCS_INT_RDY_BIT = 4;
  localparam int SCS_INT_EN_BIT = 7;
  localparam int SCS_EXT_MODE_LSB = 0;
  localparam int SCS_EXT_PER_BIT = 2;
  localparam int SCS_EXT_VLD_BIT = 7;
  localparam int SCS_MUL_EXT_BIT = 0;
  localparam int SCS_MUL_X4_BIT = 1;
  localparam int SCS_MUL_DEN_LSB = 2;
  localparam int SCS_MUL_EN_BIT = 7;

  // values after reset, plus the multiplier den limit and the base added to den
  localparam logic SCS_INT_EN_RST = 1'b1;
  localparam logic [2:0] SCS_INT_DIV_RST = 3'h0;
  localparam logic [2:0] SCS_MUL_DEN_RST = 3'h0;
  localparam logic [2:0] SCS_MUL_DEN_MAX = 3'h5;
  localparam logic [2:0] SCS_MUL_DEN_BASE = 3'h2;

  // credit added per base tick for x2 and x4
  localparam logic [4:0] SCS_MUL_ADD_X2 = 5'h04;
  localparam logic [4:0] SCS_MUL_ADD_X4 = 5'h08;

  // source ticks a crystal needs before it counts as settled
  localparam int SCS_XTAL_SETTLE_TICKS = 1024;

  typedef enum logic [1:0] {SCS_SRC_INT, SCS_SRC_EXT, SCS_SRC_MUL, SCS_SRC_RSVD} scs_src_t;
  typedef enum logic [1:0] {SCS_EXT_OFF, SCS_EXT_RC, SCS_EXT_CAP, SCS_EXT_XTAL} scs_ext_mode_t;
endpackage : scs_pkg
`default_nettype wire

//--- design/scs_mul_if.sv
`default_nettype none
interface scs_mul_if;
  logic src_tick;
  logic times4;
  logic [2:0] den;
  logic out_tick;
  modport ctrl (output src_tick, output times4, output den, input out_tick);
  modport core (input src_tick, input times4, input den, output out_tick);
endinterface : scs_mul_if
`default_nettype wire

//--- design/scs_clock_multiplier.sv
`default_nettype none
module scs_clock_multiplier
  import scs_pkg::*;
#(
  parameter int ACC_W = 5
) (
  input wire logic clk,
  input wire logic reset_n,
  scs_mul_if.core mul
);
  if (ACC_W < 5) begin : g_chk
    $error("scs_clock_multiplier: ACC_W must be at least 5");
  end

  logic [ACC_W-1:0] acc_q;
  logic [ACC_W-1:0] acc_d;
  logic out_q;
  logic out_d;

  // credit per base tick, one output tick per den units of credit
  always_comb begin
    acc_d = acc_q;
    out_d = 1'b0;
    if (mul.src_tick) begin
      acc_d = acc_d + ACC_W'(mul.times4 ? SCS_MUL_ADD_X4 : SCS_MUL_ADD_X2);
    end
    if (acc_q >= ACC_W'(mul.den)) begin
      acc_d = acc_d - ACC_W'(mul.den);
      out_d = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      acc_q <= '0;
      out_q <= 1'b0;
    end else begin
      acc_q <= acc_d;
      out_q <= out_d;
    end
  end

  assign mul.out_tick = out_q;

  a_mult_emit: assert property (@(posedge clk) disable iff (!reset_n)
    (acc_q >= ACC_W'(mul.den)) |=> mul.out_tick)
    else $error("multiplier credit did not emit a tick");
  a_mult_credit_x4: assert property (@(posedge clk) disable iff (!reset_n)
    (mul.src_tick && mul.times4 && acc_q == '0) |=> acc_q == ACC_W'(SCS_MUL_ADD_X4))
    else $error("x4 base did not add four units of two");
  a_mult_credit_x2: assert property (@(posedge clk) disable iff (!reset_n)
    (mul.src_tick && !mul.times4 && acc_q == '0) |=> acc_q == ACC_W'(SCS_MUL_ADD_X2))
    else $error("x2 base did not add two units of two");
endmodule : scs_clock_multiplier
`default_nettype wire

//--- design/scs_clock_select.sv
`default_nettype none
module scs_clock_select
  import scs_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int XTAL_SETTLE = SCS_XTAL_SETTLE_TICKS
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic int_osc_tick,
  input wire logic ext_osc_tick,
  output logic system_clock,
  output logic system_clock_tick,
  output logic ext_periph_tick,
  output logic crystal_valid_flag,
  output logic [1:0] active_source
);
  if (ADDR_W < 4 || ADDR_W > 32) begin : g_chk_addr
    $error("scs_clock_select: ADDR_W must be 4..32");
  end
  if (XTAL_SETTLE < 1 || XTAL_SETTLE > 65535) begin : g_chk_xtal
    $error("scs_clock_select: XTAL_SETTLE must be 1..65535");
  end

  localparam logic [15:0] XTAL_LAST = 16'(XTAL_SETTLE - 1);

  function automatic logic [6:0] div_mask(input logic [2:0] code);
    logic [7:0] one_hot;
    one_hot = 8'h01 << (3'h7 - code);
    return 7'(one_hot - 8'h01);
  endfunction : div_mask

  function automatic logic [7:0] word_addr(input logic [ADDR_W-1:0] a);
    return 8'({a[ADDR_W-1:2], 2'b00});
  endfunction : word_addr

  scs_src_t src_q, src_d, act_q, act_d;
  logic int_en_q, int_en_d;
  logic [2:0] int_div_q, int_div_d;
  scs_ext_mode_t ext_mode_q, ext_mode_d;
  logic per_en_q, per_en_d;
  logic mul_ext_q, mul_ext_d, mul_x4_q, mul_x4_d, mul_en_q, mul_en_d;
  logic [2:0] mul_den_q, mul_den_d;
  logic [6:0] div_cnt_q, div_cnt_d;
  logic [15:0] xtal_cnt_q, xtal_cnt_d;
  logic ext_rdy_q, ext_rdy_d;
  logic system_clock_q, system_clock_d, rise_q, rise_d, per_q, per_d;
  logic [31:0] prdata_q, prdata_d;

  logic wr, setup, mapped;
  logic int_tick, ext_tick, div_tick, sel_tick;
  logic [31:0] rd_word;
  scs_mul_if mul_bus ();

  assign setup = psel && !penable;
  assign wr = psel && penable && pwrite;
  assign int_tick = int_osc_tick && int_en_q;
  assign ext_tick = ext_osc_tick && (ext_mode_q != SCS_EXT_OFF);
  assign div_tick = int_tick && ((div_cnt_q & div_mask(int_div_q)) == div_mask(int_div_q));

  always_comb begin
    case (word_addr(paddr))
      SCS_OFF_SRC, SCS_OFF_INT, SCS_OFF_EXT, SCS_OFF_MUL: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // multiplier base: internal or external, before the internal divider
  assign mul_bus.src_tick = mul_en_q && (mul_ext_q ? ext_tick : int_tick);
  assign mul_bus.times4 = mul_x4_q;
  assign mul_bus.den = mul_den_q + SCS_MUL_DEN_BASE;

  scs_clock_multiplier #(.ACC_W(5)) u_mult (
    .clk(clk),
    .reset_n(reset_n),
    .mul(mul_bus.core)
  );

  always_comb begin
    case (act_q)
      SCS_SRC_INT: sel_tick = div_tick;
      SCS_SRC_EXT: sel_tick = ext_tick;
      SCS_SRC_MUL: sel_tick = mul_bus.out_tick;
      default: sel_tick = 1'b0;
    endcase
  end

  // register file
  always_comb begin
    src_d = src_q;
    int_en_d = int_en_q;
    int_div_d = int_div_q;
    ext_mode_d = ext_mode_q;
    per_en_d = per_en_q;
    mul_ext_d = mul_ext_q;
    mul_x4_d = mul_x4_q;
    mul_den_d = mul_den_q;
    mul_en_d = mul_en_q;
    if (wr) begin
      case (word_addr(paddr))
        SCS_OFF_SRC: begin
          if (pwdata[SCS_SRC_LSB +: 2] != 2'b11) begin
            src_d = scs_src_t'(pwdata[SCS_SRC_LSB +: 2]);
          end
        end
        SCS_OFF_INT: begin
          int_en_d = pwdata[SCS_INT_EN_BIT];
          int_div_d = pwdata[SCS_INT_DIV_LSB +: 3];
        end
        SCS_OFF_EXT: begin
          ext_mode_d = scs_ext_mode_t'(pwdata[SCS_EXT_MODE_LSB +: 2]);
          per_en_d = pwdata[SCS_EXT_PER_BIT];
        end
        SCS_OFF_MUL: begin
          mul_ext_d = pwdata[SCS_MUL_EXT_BIT];
          mul_x4_d = pwdata[SCS_MUL_X4_BIT];
          mul_en_d = pwdata[SCS_MUL_EN_BIT];
          if (pwdata[SCS_MUL_DEN_LSB +: 3] <= SCS_MUL_DEN_MAX) begin
            mul_den_d = pwdata[SCS_MUL_DEN_LSB +: 3];
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      src_q <= SCS_SRC_INT;
      int_en_q <= SCS_INT_EN_RST;
      int_div_q <= SCS_INT_DIV_RST;
      ext_mode_q <= SCS_EXT_OFF;
      per_en_q <= 1'b0;
      mul_ext_q <= 1'b0;
      mul_x4_q <= 1'b0;
      mul_den_q <= SCS_MUL_DEN_RST;
      mul_en_q <= 1'b0;
    end else begin
      src_q <= src_d;
      int_en_q <= int_en_d;
      int_div_q <= int_div_d;
      ext_mode_q <= ext_mode_d;
      per_en_q <= per_en_d;
      mul_ext_q <= mul_ext_d;
      mul_x4_q <= mul_x4_d;
      mul_den_q <= mul_den_d;
      mul_en_q <= mul_en_d;
    end
  end

  // oscillator state: divider, crystal settle, output clock, switching
  always_comb begin
    div_cnt_d = int_tick ? div_cnt_q + 7'h01 : div_cnt_q;
    xtal_cnt_d = xtal_cnt_q;
    ext_rdy_d = ext_rdy_q;
    case (ext_mode_q)
      SCS_EXT_RC, SCS_EXT_CAP: ext_rdy_d = 1'b1;
      SCS_EXT_XTAL: begin
        if (ext_osc_tick && !ext_rdy_q) begin
          if (xtal_cnt_q == XTAL_LAST) begin
            ext_rdy_d = 1'b1;
          end else begin
            xtal_cnt_d = xtal_cnt_q + 16'h0001;
          end
        end
      end
      default: begin
        ext_rdy_d = 1'b0;
        xtal_cnt_d = 16'h0000;
      end
    endcase
    if (ext_mode_d != ext_mode_q) begin
      ext_rdy_d = 1'b0;
      xtal_cnt_d = 16'h0000;
    end
    act_d = act_q;
    system_clock_d = system_clock_q;
    rise_d = 1'b0;
    if (sel_tick) begin
      system_clock_d = !system_clock_q;
      rise_d = !system_clock_q;
      // hand over only on a falling edge, so the high phase is whole
      if (system_clock_q && src_q != act_q) begin
        act_d = src_q;
      end
    end
    per_d = ext_osc_tick && per_en_q && ext_mode_q != SCS_EXT_OFF;
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      div_cnt_q <= 7'h00;
      xtal_cnt_q <= 16'h0000;
      ext_rdy_q <= 1'b0;
      act_q <= SCS_SRC_INT;
      system_clock_q <= 1'b0;
      rise_q <= 1'b0;
      per_q <= 1'b0;
    end else begin
      div_cnt_q <= div_cnt_d;
      xtal_cnt_q <= xtal_cnt_d;
      ext_rdy_q <= ext_rdy_d;
      act_q <= act_d;
      system_clock_q <= system_clock_d;
      rise_q <= rise_d;
      per_q <= per_d;
    end
  end

  // read data captured in the setup cycle, ready in the access cycle
  always_comb begin
    rd_word = 32'h0000_0000;
    case (word_addr(paddr))
      SCS_OFF_SRC: begin
        rd_word[SCS_SRC_LSB +: 2] = src_q;
        rd_word[SCS_ACT_LSB +: 2] = act_q;
      end
      SCS_OFF_INT: begin
        rd_word[SCS_INT_EN_BIT] = int_en_q;
        rd_word[SCS_INT_RDY_BIT] = int_en_q;
        rd_word[SCS_INT_DIV_LSB +: 3] = int_div_q;
      end
      SCS_OFF_EXT: begin
        rd_word[SCS_EXT_MODE_LSB +: 2] = ext_mode_q;
        rd_word[SCS_EXT_PER_BIT] = per_en_q;
        rd_word[SCS_EXT_VLD_BIT] = ext_rdy_q;
      end
      SCS_OFF_MUL: begin
        rd_word[SCS_MUL_EXT_BIT] = mul_ext_q;
        rd_word[SCS_MUL_X4_BIT] = mul_x4_q;
        rd_word[SCS_MUL_DEN_LSB +: 3] = mul_den_q;
        rd_word[SCS_MUL_EN_BIT] = mul_en_q;
      end
      default: rd_word = 32'h0000_0000;
    endcase
    prdata_d = setup ? rd_word : prdata_q;
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      prdata_q <= 32'h0000_0000;
    end else begin
      prdata_q <= prdata_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign system_clock = system_clock_q;
  assign system_clock_tick = rise_q;
  assign ext_periph_tick = per_q;
  assign crystal_valid_flag = ext_rdy_q;
  assign active_source = act_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  a_reset_default_src: assert property (
    $rose(reset_n) |-> act_q == SCS_SRC_INT && int_div_q == 3'h0 && int_en_q)
    else $error("reset did not leave internal oscillator divided by 128");
  a_rsvd_sel_kept: assert property (
    (wr && word_addr(paddr) == SCS_OFF_SRC && pwdata[1:0] == 2'b11) |=> $stable(src_q))
    else $error("reserved select value was accepted");
  a_ext_route: assert property (
    (act_q == SCS_SRC_EXT && ext_tick) |=> system_clock_q != $past(system_clock_q))
    else $error("external tick did not toggle system clock");
  a_periph_ext: assert property (
    (ext_osc_tick && per_en_q && ext_mode_q != SCS_EXT_OFF) |=> ext_periph_tick)
    else $error("peripheral tick missing while external enabled");
  a_switch_no_runt: assert property (
    (act_q != $past(act_q)) |-> $fell(system_clock_q))
    else $error("source changed away from a falling edge");
  a_switch_waits_tick: assert property (
    (src_q != act_q && !sel_tick) |=> act_q == $past(act_q))
    else $error("source changed without a tick of the old source");
  a_int_ready_now: assert property (
    (wr && word_addr(paddr) == SCS_OFF_INT && pwdata[SCS_INT_EN_BIT]) |=> int_en_q ##0 int_tick == int_osc_tick)
    else $error("internal oscillator not usable after enable");
  a_rc_no_wait: assert property (
    (ext_mode_q inside {SCS_EXT_RC, SCS_EXT_CAP} && $stable(ext_mode_q)) |->
      crystal_valid_flag)
    else $error("rc or c mode not ready at once");
  a_xtal_settle: assert property (
    (ext_mode_q == SCS_EXT_XTAL && xtal_cnt_q == XTAL_LAST && ext_osc_tick && !wr) |=>
      crystal_valid_flag)
    else $error("crystal valid not set after settle count");
  a_div_by_one: assert property (
    (int_div_q == 3'h7 && int_tick) |-> div_tick)
    else $error("divide by one skipped an internal tick");

  c_switch_ext: cover property (act_q == SCS_SRC_INT ##1 act_q == SCS_SRC_EXT);
  c_switch_mul: cover property (act_q != SCS_SRC_MUL ##1 act_q == SCS_SRC_MUL);
  c_xtal_valid: cover property (ext_mode_q == SCS_EXT_XTAL && $rose(crystal_valid_flag));
  c_periph_on_int: cover property (act_q == SCS_SRC_INT && ext_periph_tick);
endmodule : scs_clock_select
`default_nettype wire

//--- testbench/scs_osc_model.sv
`default_nettype none
module scs_osc_model (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [3:0] int_per,
  input wire logic [3:0] ext_per,
  input wire logic ext_run,
  output logic int_tick,
  output logic ext_tick
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] ic_q;
  logic [3:0] ec_q;
  // a stopped resonator gives no edges at all
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ic_q <= 4'h0;
      ec_q <= 4'h0;
      int_tick <= 1'b0;
      ext_tick <= 1'b0;
    end else begin
      ic_q <= (ic_q >= int_per - 4'h1) ? 4'h0 : ic_q + 4'h1;
      int_tick <= (ic_q == int_per - 4'h1);
      ec_q <= (!ext_run || ec_q >= ext_per - 4'h1) ? 4'h0 : ec_q + 4'h1;
      ext_tick <= ext_run && (ec_q == ext_per - 4'h1);
    end
  end
endmodule : scs_osc_model
`default_nettype wire

//--- testbench/testbench.sv
`default_nettype none
module testbench
  import scs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic wr; logic [7:0] a; logic [31:0] d; logic [31:0] e; logic err;} scs_row_t;
  logic clk, reset_n, psel, penable, pwrite, pready, pslverr, ext_run, mon, er, last;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic int_osc_tick, ext_osc_tick, system_clock, system_clock_tick, ext_periph_tick;
  logic crystal_valid_flag;
  logic [1:0] active_source;
  logic [3:0] int_per, ext_per;
  int failures = 0;
  int samples_checked = 0;
  int cyc = 0;
  int run = 0;
  int c, i;
  scs_row_t rows [12];
  logic [7:0] mcfg [9];
  int mexp [9];

  scs_clock_select #(.XTAL_SETTLE(4)) i_scs_clock_select (.clk(clk), .reset_n(reset_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .int_osc_tick(int_osc_tick),
    .ext_osc_tick(ext_osc_tick), .system_clock(system_clock),
    .system_clock_tick(system_clock_tick), .ext_periph_tick(ext_periph_tick),
    .crystal_valid_flag(crystal_valid_flag), .active_source(active_source));
  scs_osc_model i_scs_osc_model (.clk(clk), .reset_n(reset_n), .int_per(int_per),
    .ext_per(ext_per), .ext_run(ext_run), .int_tick(int_osc_tick), .ext_tick(ext_osc_tick));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task test_done;
    if (failures == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : test_done

  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
           output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    penable <= 1'b0;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      @(posedge clk);
      n++;
    end
    chk("pready_wait", n, 32'h0);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // count pulses over nt source ticks, aligned to a source tick
  task cnt(input logic pick, input logic use_ext, input int per, input int nt, output int n);
    int w;
    w = 0;
    n = 0;
    @(posedge clk);
    while ((use_ext ? ext_osc_tick : int_osc_tick) !== 1'b1 && w < 100) begin
      @(posedge clk);
      w++;
    end
    repeat (nt * per) begin
      @(posedge clk);
      n += ((pick ? ext_periph_tick : system_clock_tick) === 1'b1);
    end
  endtask : cnt

  task wt(input logic flag, input logic [1:0] v, input int lim);
    int n;
    n = 0;
    while ((flag ? {1'b0, crystal_valid_flag} : active_source) !== v && n < lim) begin
      @(posedge clk);
      n++;
    end
    chk("wait", {30'h0, flag ? {1'b0, crystal_valid_flag} : active_source}, {30'h0, v});
  endtask : wt

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      failures++;
      test_done();
    end
  end

  // no level of the system clock may be shorter than the fastest source allows
  always @(posedge clk) begin
    if (system_clock !== last) begin
      if (mon) chk("level_len", {31'h0, run >= 2}, 32'h1);
      run = 1;
    end else begin
      run++;
    end
    last = system_clock;
  end

  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    reset_n = 1'b0;
    int_per = 4'h2;
    ext_per = 4'h8;
    ext_run = 1'b1;
    mon = 1'b0;
    rows = '{'{1'b0, 8'h00, 32'h0, 32'h0, 1'b0}, '{1'b0, 8'h04, 32'h0, 32'h90, 1'b0},
             '{1'b0, 8'h08, 32'h0, 32'h0, 1'b0}, '{1'b0, 8'h0C, 32'h0, 32'h0, 1'b0},
             '{1'b0, 8'h10, 32'h0, 32'h0, 1'b1}, '{1'b1, 8'h10, 32'hFF, 32'h0, 1'b1},
             '{1'b1, 8'h04, 32'h07, 32'h0, 1'b0}, '{1'b0, 8'h04, 32'h0, 32'h07, 1'b0},
             '{1'b1, 8'h04, 32'h87, 32'h0, 1'b0}, '{1'b0, 8'h04, 32'h0, 32'h97, 1'b0},
             '{1'b1, 8'h0C, 32'hFF, 32'h0, 1'b0}, '{1'b0, 8'h0C, 32'h0, 32'h83, 1'b0}};
    mcfg = '{8'h81, 8'h85, 8'h89, 8'h8D, 8'h91, 8'h95, 8'h80, 8'h96, 8'h83};
    mexp = '{420, 280, 210, 168, 140, 120, 420, 240, 840};
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    chk("active_rst", {30'h0, active_source}, 32'h0);
    for (i = 0; i < 12; i++) begin
      apb(rows[i].wr, rows[i].a, rows[i].d, rd, er);
      if (!rows[i].wr) chk("rdata", rd, rows[i].e);
      chk("slverr", {31'h0, er}, {31'h0, rows[i].err});
    end
    for (i = 0; i < 8; i++) begin
      apb(1'b1, SCS_OFF_INT, 32'h80 | i, rd, er);
      cnt(1'b0, 1'b0, 2, 256, c);
      chk("int_div", c, 128 >> (7 - i));
    end
    apb(1'b1, SCS_OFF_EXT, 32'h05, rd, er);
    wt(1'b1, 2'h1, 4);
    cnt(1'b1, 1'b1, 8, 16, c);
    chk("periph_on", c, 16);
    mon = 1'b1;
    apb(1'b1, SCS_OFF_SRC, 32'h1, rd, er);
    wt(1'b0, 2'h1, 40);
    cnt(1'b0, 1'b1, 8, 16, c);
    chk("ext_rate", c, 8);
    apb(1'b1, SCS_OFF_SRC, 32'h3, rd, er);
    apb(1'b0, SCS_OFF_SRC, 32'h0, rd, er);
    chk("src_rsvd", rd, 32'h11);
    apb(1'b1, SCS_OFF_SRC, 32'h0, rd, er);
    wt(1'b0, 2'h0, 40);
    mon = 1'b0;
    apb(1'b1, SCS_OFF_EXT, 32'h02, rd, er);
    @(posedge clk);
    wt(1'b1, 2'h1, 4);
    cnt(1'b1, 1'b1, 8, 16, c);
    chk("periph_off", c, 0);
    int_per <= 4'h8;
    apb(1'b1, SCS_OFF_MUL, 32'h81, rd, er);
    apb(1'b1, SCS_OFF_SRC, 32'h2, rd, er);
    wt(1'b0, 2'h2, 100);
    for (i = 0; i < 9; i++) begin
      apb(1'b1, SCS_OFF_MUL, {24'h0, mcfg[i]}, rd, er);
      cnt(1'b0, mcfg[i][0], 8, 2, c);
      cnt(1'b0, mcfg[i][0], 8, 420, c);
      chk("mul_rate", c, mexp[i]);
    end
    apb(1'b1, SCS_OFF_SRC, 32'h0, rd, er);
    wt(1'b0, 2'h0, 100);
    ext_run <= 1'b0;
    apb(1'b1, SCS_OFF_EXT, 32'h03, rd, er);
    repeat (40) @(posedge clk);
    chk("xtal_idle", {31'h0, crystal_valid_flag}, 32'h0);
    ext_run <= 1'b1;
    // one millisecond before trusting the flag
    repeat (10000) @(posedge clk);
    apb(1'b0, SCS_OFF_EXT, 32'h0, rd, er);
    chk("xtal_valid", rd, 32'h83);
    // reset in mid-run while the settled crystal drives the system clock
    apb(1'b1, SCS_OFF_SRC, 32'h1, rd, er);
    wt(1'b0, 2'h1, 40);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    chk("active_rst2", {30'h0, active_source}, 32'h0);
    apb(1'b0, SCS_OFF_INT, 32'h0, rd, er);
    chk("int_rst2", rd, 32'h90);
    test_done();
  end
endmodule : testbench
`default_nettype wire
